// *** inc/tpwc_consts.vh ***
// Register indices, field positions and reset values of the timer and pulse-width control block.
`ifndef TPWC_CONSTS_VH
`define TPWC_CONSTS_VH
`define TPWC_IDX_WAKEUP 6'h06
`define TPWC_IDX_TCC_CTRL 6'h07
`define TPWC_IDX_WDT_CTRL 6'h08
`define TPWC_IDX_CNT_CTRL 6'h09
`define TPWC_IDX_WIDTH_CTRL 6'h0a
`define TPWC_IDX_HIGH_PRESET 6'h0d
`define TPWC_IDX_LOW_PRESET 6'h0e
`define TPWC_IDX_IRQ_MASK 6'h0f
`define TPWC_IDX_PAGE 6'h10
`define TPWC_IDX_IRQ_STATUS 6'h11
`define TPWC_IDX_PULSE_MODE 6'h12
`define TPWC_IDX_CNT1_PRESET 6'h13
`define TPWC_IDX_CNT2_PRESET 6'h14
`define TPWC_IDX_TCC_VALUE 6'h15
`define TPWC_PAGE_BIT 0
`define TPWC_DRIVE_BIT 7
`define TPWC_EDGE0_BIT 7
`define TPWC_GIE_BIT 6
`define TPWC_TS_BIT 5
`define TPWC_TE_BIT 4
`define TPWC_COUNTER_PRESCALE_ENABLE_BIT 3
`define TPWC_WATCHDOG_ENABLE_BIT_BIT 3
`define TPWC_HI_SRC_BIT 7
`define TPWC_LO_SRC_BIT 3
`define TPWC_OUT_EN_BIT 0
`define TPWC_LONG_LOW_BIT 1
`define TPWC_CNT1_RUN_BIT 2
`define TPWC_CNT2_RUN_BIT 3
`define TPWC_IRQ_PIN 7
`define TPWC_IRQ_LOW 6
`define TPWC_IRQ_HIGH 5
`define TPWC_IRQ_CNT2 4
`define TPWC_IRQ_CNT1 3
`define TPWC_IRQ_EXT1 2
`define TPWC_IRQ_EXT0 1
`define TPWC_IRQ_TCC 0
`define TPWC_RST_WAKEUP 8'h00
`define TPWC_RST_TCC_CTRL 8'hbf
`define TPWC_RST_ZERO 8'h00
`define TPWC_ALL_ONES 8'hff
`define TPWC_WDT_MASK 8'h0f
`define TPWC_WAKE_MASK 8'h8f
`define TPWC_MODE_MASK 8'h0f
`define TPWC_HTRANS_NONSEQ 2'b10
`endif

// *** rtl/tpwc_top.v ***
// Timer, pulse-width output, watchdog and interrupt control block with an AHB-Lite slave.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "tpwc_consts.vh"
// How it works
// - High-width timer is an 8-bit down-counter with prescaler, preset reloads on underflow.
// - High phase lasts prescaler ratio times high preset plus one source ticks.
// - Low-width timer is an 8-bit down-counter with prescaler, preset reloads on underflow.
// - Low phase lasts prescaler ratio times low preset plus one source ticks.
// - Interrupt mask holds one read-write enable bit per source, one enables.
// - Wake-up register bit 7 selects low or high drive of the pulse pin.
// - Wake-up bits 3 to 0 are active-low nibble pin-change wake enables.
// - Pin-change wake-up starts enabled after reset.
// - Edge select makes external interrupt zero rising when 0, falling when 1.
// - Global interrupt enable is read-only, cleared by disable or entry, set by enable/return.
// - Counter source bit picks instruction clock when 0, counter pin when 1.
// - Counter edge bit picks rising pin edges when 0, falling when 1.
// - Counter prescaler off gives 1:1, on gives 1:2 to 1:256.
// - Watchdog enable bit turns the watchdog on when 1.
// - Watchdog runs from the sub-oscillator with ratios 1:1 to 1:128.
// - Counter control bit 7 clocks counter two from sub or main oscillator.
// - Counter control bits 6 to 4 set counter two prescale 1:2 to 1:256.
// - Counter control bit 3 clocks counter one from sub or main oscillator.
// - Counter control bits 2 to 0 set counter one prescale 1:2 to 1:256.
// - Width control bit 7 and bits 6 to 4 set low timer source and prescale.
// - Width control bit 3 and bits 2 to 0 set high timer source and prescale.
// - Each source sets its own flag in the interrupt status register.
// - Page bit selects which control registers the shared indices reach.
// - Long-low option ignores the high preset; the low timer shapes the output alone.

module tpwc_down_timer (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Control.
  input wire tick,
  input wire run,
  input wire load,
  input wire [7:0] preset,
  input wire [2:0] ps_code,
  // Status.
  output reg [7:0] count,
  output wire underflow
);
  reg [7:0] pre;
  wire [7:0] term;

  // Ratio 2^(code+1) means a terminal prescaler count of that minus one.
  assign term = `TPWC_ALL_ONES >> (3'd7 - ps_code);
  assign underflow = run & tick & (pre == term) & (count == `TPWC_RST_ZERO);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre <= `TPWC_RST_ZERO;
      count <= `TPWC_RST_ZERO;
    end
    else if (load)
    begin
      pre <= `TPWC_RST_ZERO;
      count <= preset;
    end
    else if (run && tick)
    begin
      if (pre == term)
      begin
        pre <= `TPWC_RST_ZERO;
        count <= (count == `TPWC_RST_ZERO) ? preset : count - 8'h01;
      end
      else
      begin
        pre <= pre + 8'h01;
      end
    end
  end
endmodule

module tpwc_top (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Time bases, each a one-cycle tick.
  input wire instr_tick,
  input wire sub_osc_clock,
  input wire main_osc_clock,
  // Core events.
  input wire disable_irq_instruction,
  input wire enable_irq_instruction,
  input wire return_irq_instruction,
  input wire irq_entry,
  input wire wdt_clear,
  // Pins.
  input wire counter_pin,
  input wire ext_irq_zero_pin,
  input wire ext_irq_one_pin,
  input wire [7:0] porta_in,
  input wire [7:0] portb_in,
  output reg pulse_output_pin,
  output wire output_drive_select,
  // Results.
  output reg wake_request,
  output reg watchdog_reset,
  output wire cpu_irq_request
);
  localparam RD_IDLE = 2'b01;
  localparam RD_FETCH = 2'b10;

  reg [7:0] wakeup_drive_reg;
  reg [7:0] time_counter_ctrl_reg;
  reg [7:0] watchdog_ctrl_reg;
  reg [7:0] counter_pair_ctrl_reg;
  reg [7:0] width_timer_ctrl_reg;
  reg [7:0] high_width_preset_reg;
  reg [7:0] low_width_preset_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] page_select_reg;
  reg [7:0] irq_status;
  reg [7:0] pulse_mode_reg;
  reg [7:0] cnt1_preset;
  reg [7:0] cnt2_preset;
  reg [7:0] time_clock_counter;
  reg [7:0] tcc_pre;
  reg [7:0] wdt_pre;
  reg [7:0] wdt_count;
  reg global_irq_en;
  reg wr_pend;
  reg [5:0] wr_idx;
  reg [5:0] rd_idx;
  reg [1:0] rd_state;
  reg counter_pin_d;
  reg ext0_d;
  reg ext1_d;
  reg [7:0] porta_d;
  reg [7:0] portb_d;
  reg out_running;
  reg [7:0] next_status;
  reg [7:0] events;
  wire addr_ok;
  wire [5:0] a_idx;
  wire wr_any;
  wire [7:0] wd;
  wire page_one;
  wire tcc_step;
  wire tcc_src;
  wire [7:0] tcc_term;
  wire [7:0] wdt_term;
  wire hi_tick;
  wire lo_tick;
  wire hi_run;
  wire lo_run;
  wire hi_uf;
  wire lo_uf;
  wire c1_uf;
  wire c2_uf;
  wire long_low;
  wire [3:0] nib_change;

  // Decodes an index to its register, honouring the page bit.
  function sel;
    input [5:0] idx;
    input [5:0] target;
    input pg;
    begin
      if (target == `TPWC_IDX_HIGH_PRESET || target == `TPWC_IDX_LOW_PRESET
          || target == `TPWC_IDX_IRQ_MASK)
        sel = (idx == target) && !pg;
      else if (target < `TPWC_IDX_HIGH_PRESET)
        sel = (idx == target) && pg;
      else
        sel = (idx == target);
    end
  endfunction

  assign a_idx = haddr[7:2];
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  assign hreadyout = (rd_state != RD_FETCH);
  assign hresp = 1'b0;
  assign wd = hwdata[7:0];
  assign wr_any = wr_pend;
  assign page_one = page_select_reg[`TPWC_PAGE_BIT];

  // Address phase capture; reads take one wait state so the data is fresh.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
      rd_idx <= 6'h00;
      rd_state <= RD_IDLE;
      hrdata <= 32'h00000000;
    end
    else
    begin
      case (rd_state)
        RD_FETCH:
        begin
          rd_state <= RD_IDLE;
          hrdata <= {24'h000000, read_mux(rd_idx)};
        end
        default:
        begin
          if (hready)
          begin
            wr_pend <= hsel && (htrans == `TPWC_HTRANS_NONSEQ) && hwrite && addr_ok;
            wr_idx <= a_idx;
            rd_idx <= a_idx;
            if (hsel && (htrans == `TPWC_HTRANS_NONSEQ) && !hwrite)
              rd_state <= RD_FETCH;
            hrdata <= 32'h00000000;
          end
        end
      endcase
      if (hready && !(hsel && (htrans == `TPWC_HTRANS_NONSEQ) && !hwrite && addr_ok))
        rd_idx <= 6'h3f;
    end
  end

  // Read multiplexer; unmapped and hidden-page indices read as zero.
  function [7:0] read_mux;
    input [5:0] idx;
    begin
      read_mux = 8'h00;
      // wake enables are readable with drive bit
      if (sel(idx, `TPWC_IDX_WAKEUP, page_one))
        read_mux = wakeup_drive_reg;
      if (sel(idx, `TPWC_IDX_TCC_CTRL, page_one))
        read_mux = {time_counter_ctrl_reg[7], global_irq_en, time_counter_ctrl_reg[5:0]};
      if (sel(idx, `TPWC_IDX_WDT_CTRL, page_one))
        read_mux = watchdog_ctrl_reg;
      if (sel(idx, `TPWC_IDX_CNT_CTRL, page_one))
        read_mux = counter_pair_ctrl_reg;
      if (sel(idx, `TPWC_IDX_WIDTH_CTRL, page_one))
        read_mux = width_timer_ctrl_reg;
      if (sel(idx, `TPWC_IDX_HIGH_PRESET, page_one))
        read_mux = high_width_preset_reg;
      if (sel(idx, `TPWC_IDX_LOW_PRESET, page_one))
        read_mux = low_width_preset_reg;
      if (sel(idx, `TPWC_IDX_IRQ_MASK, page_one))
        read_mux = irq_mask_reg;
      if (sel(idx, `TPWC_IDX_PAGE, page_one))
        read_mux = page_select_reg;
      if (sel(idx, `TPWC_IDX_IRQ_STATUS, page_one))
        read_mux = irq_status;
      if (sel(idx, `TPWC_IDX_PULSE_MODE, page_one))
        read_mux = pulse_mode_reg;
      if (sel(idx, `TPWC_IDX_CNT1_PRESET, page_one))
        read_mux = cnt1_preset;
      if (sel(idx, `TPWC_IDX_CNT2_PRESET, page_one))
        read_mux = cnt2_preset;
      if (sel(idx, `TPWC_IDX_TCC_VALUE, page_one))
        read_mux = time_clock_counter;
    end
  endfunction

  // Software-written registers.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wakeup_drive_reg <= `TPWC_RST_WAKEUP;
      time_counter_ctrl_reg <= `TPWC_RST_TCC_CTRL;
      watchdog_ctrl_reg <= `TPWC_RST_ZERO;
      counter_pair_ctrl_reg <= `TPWC_RST_ZERO;
      width_timer_ctrl_reg <= `TPWC_RST_ZERO;
      high_width_preset_reg <= `TPWC_RST_ZERO;
      low_width_preset_reg <= `TPWC_RST_ZERO;
      irq_mask_reg <= `TPWC_RST_ZERO;
      page_select_reg <= `TPWC_RST_ZERO;
      pulse_mode_reg <= `TPWC_RST_ZERO;
      cnt1_preset <= `TPWC_RST_ZERO;
      cnt2_preset <= `TPWC_RST_ZERO;
    end
    else if (wr_any)
    begin
      if (sel(wr_idx, `TPWC_IDX_WAKEUP, page_one))
        wakeup_drive_reg <= wd & `TPWC_WAKE_MASK;
      if (sel(wr_idx, `TPWC_IDX_TCC_CTRL, page_one))
        time_counter_ctrl_reg <= wd;
      if (sel(wr_idx, `TPWC_IDX_WDT_CTRL, page_one))
        watchdog_ctrl_reg <= wd & `TPWC_WDT_MASK;
      if (sel(wr_idx, `TPWC_IDX_CNT_CTRL, page_one))
        counter_pair_ctrl_reg <= wd;
      if (sel(wr_idx, `TPWC_IDX_WIDTH_CTRL, page_one))
        width_timer_ctrl_reg <= wd;
      if (sel(wr_idx, `TPWC_IDX_HIGH_PRESET, page_one))
        high_width_preset_reg <= wd;
      if (sel(wr_idx, `TPWC_IDX_LOW_PRESET, page_one))
        low_width_preset_reg <= wd;
      if (sel(wr_idx, `TPWC_IDX_IRQ_MASK, page_one))
        irq_mask_reg <= wd;
      if (sel(wr_idx, `TPWC_IDX_PAGE, page_one))
        page_select_reg <= {7'h00, wd[`TPWC_PAGE_BIT]};
      if (sel(wr_idx, `TPWC_IDX_PULSE_MODE, page_one))
        pulse_mode_reg <= wd & `TPWC_MODE_MASK;
      if (sel(wr_idx, `TPWC_IDX_CNT1_PRESET, page_one))
        cnt1_preset <= wd;
      if (sel(wr_idx, `TPWC_IDX_CNT2_PRESET, page_one))
        cnt2_preset <= wd;
    end
  end

  assign output_drive_select = wakeup_drive_reg[`TPWC_DRIVE_BIT];

  // Pulse-width output generator.
  // long-low disables the high timer
  assign long_low = pulse_mode_reg[`TPWC_LONG_LOW_BIT];
  assign hi_tick = width_timer_ctrl_reg[`TPWC_LO_SRC_BIT] ? main_osc_clock : sub_osc_clock;
  assign lo_tick = width_timer_ctrl_reg[`TPWC_HI_SRC_BIT] ? main_osc_clock : sub_osc_clock;
  // high timer runs only through the high phase
  assign hi_run = out_running && pulse_output_pin && !long_low;
  // low timer runs through the low phase, or always in long-low mode
  assign lo_run = out_running && (!pulse_output_pin || long_low);

  tpwc_down_timer u_high (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(hi_tick),
    .run(hi_run),
    .load(!hi_run),
    .preset(high_width_preset_reg),
    .ps_code(width_timer_ctrl_reg[2:0]),
    .count(),
    .underflow(hi_uf)
  );

  tpwc_down_timer u_low (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(lo_tick),
    .run(lo_run),
    .load(!lo_run),
    .preset(low_width_preset_reg),
    .ps_code(width_timer_ctrl_reg[6:4]),
    .count(),
    .underflow(lo_uf)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_running <= 1'b0;
      pulse_output_pin <= 1'b0;
    end
    else if (!pulse_mode_reg[`TPWC_OUT_EN_BIT])
    begin
      out_running <= 1'b0;
      pulse_output_pin <= 1'b0;
    end
    else if (!out_running)
    begin
      out_running <= 1'b1;
      pulse_output_pin <= 1'b1;
    end
    // high phase ends on high underflow
    else if (hi_uf)
      pulse_output_pin <= 1'b0;
    // low underflow ends the low phase, or toggles the output in long-low mode
    else if (lo_uf)
      pulse_output_pin <= long_low ? !pulse_output_pin : 1'b1;
  end

  // Counters one and two.
  tpwc_down_timer u_cnt1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(counter_pair_ctrl_reg[`TPWC_LO_SRC_BIT] ? main_osc_clock : sub_osc_clock),
    .run(pulse_mode_reg[`TPWC_CNT1_RUN_BIT]),
    .load(!pulse_mode_reg[`TPWC_CNT1_RUN_BIT]),
    .preset(cnt1_preset),
    .ps_code(counter_pair_ctrl_reg[2:0]),
    .count(),
    .underflow(c1_uf)
  );

  tpwc_down_timer u_cnt2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(counter_pair_ctrl_reg[`TPWC_HI_SRC_BIT] ? main_osc_clock : sub_osc_clock),
    .run(pulse_mode_reg[`TPWC_CNT2_RUN_BIT]),
    .load(!pulse_mode_reg[`TPWC_CNT2_RUN_BIT]),
    .preset(cnt2_preset),
    .ps_code(counter_pair_ctrl_reg[6:4]),
    .count(),
    .underflow(c2_uf)
  );

  // Time-clock counter.
  // source select
  assign tcc_src = time_counter_ctrl_reg[`TPWC_TS_BIT] ?
    (time_counter_ctrl_reg[`TPWC_TE_BIT] ? (counter_pin_d && !counter_pin) :
     (!counter_pin_d && counter_pin)) : instr_tick;
  assign tcc_term = `TPWC_ALL_ONES >> (3'd7 - time_counter_ctrl_reg[2:0]);
  assign tcc_step = tcc_src && (!time_counter_ctrl_reg[`TPWC_COUNTER_PRESCALE_ENABLE_BIT] || tcc_pre == tcc_term);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      time_clock_counter <= `TPWC_RST_ZERO;
      tcc_pre <= `TPWC_RST_ZERO;
    end
    else if (wr_any && sel(wr_idx, `TPWC_IDX_TCC_VALUE, page_one))
    begin
      time_clock_counter <= wd;
      tcc_pre <= `TPWC_RST_ZERO;
    end
    else if (tcc_step)
    begin
      time_clock_counter <= time_clock_counter + 8'h01;
      tcc_pre <= `TPWC_RST_ZERO;
    end
    else if (tcc_src)
      tcc_pre <= tcc_pre + 8'h01;
  end

  // Watchdog on the sub-oscillator.
  // ratios 1:1 to 1:128
  assign wdt_term = `TPWC_ALL_ONES >> (4'd8 - {1'b0, watchdog_ctrl_reg[2:0]});

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdt_pre <= `TPWC_RST_ZERO;
      wdt_count <= `TPWC_RST_ZERO;
      watchdog_reset <= 1'b0;
    end
    else if (!watchdog_ctrl_reg[`TPWC_WATCHDOG_ENABLE_BIT_BIT] || wdt_clear)
    begin
      wdt_pre <= `TPWC_RST_ZERO;
      wdt_count <= `TPWC_RST_ZERO;
      watchdog_reset <= 1'b0;
    end
    else
    begin
      watchdog_reset <= 1'b0;
      if (sub_osc_clock)
      begin
        if (wdt_pre == wdt_term)
        begin
          wdt_pre <= `TPWC_RST_ZERO;
          wdt_count <= wdt_count + 8'h01;
          watchdog_reset <= (wdt_count == `TPWC_ALL_ONES);
        end
        else
          wdt_pre <= wdt_pre + 8'h01;
      end
    end
  end

  // Pin edges, wake-up and interrupt flags.
  assign nib_change = {portb_in[7:4] != portb_d[7:4], portb_in[3:0] != portb_d[3:0],
                       porta_in[7:4] != porta_d[7:4], porta_in[3:0] != porta_d[3:0]};

  always @*
  begin
    events = 8'h00;
    events[`TPWC_IRQ_PIN] = |nib_change;
    events[`TPWC_IRQ_LOW] = lo_uf;
    events[`TPWC_IRQ_HIGH] = hi_uf;
    events[`TPWC_IRQ_CNT2] = c2_uf;
    events[`TPWC_IRQ_CNT1] = c1_uf;
    events[`TPWC_IRQ_EXT1] = !ext1_d && ext_irq_one_pin;
    // edge select for external interrupt zero
    events[`TPWC_IRQ_EXT0] = time_counter_ctrl_reg[`TPWC_EDGE0_BIT] ?
      (ext0_d && !ext_irq_zero_pin) : (!ext0_d && ext_irq_zero_pin);
    events[`TPWC_IRQ_TCC] = tcc_step && (time_clock_counter == `TPWC_ALL_ONES);
    next_status = irq_status;
    if (wr_any && sel(wr_idx, `TPWC_IDX_IRQ_STATUS, page_one))
      next_status = irq_status & ~wd;
    next_status = next_status | events;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= `TPWC_RST_ZERO;
      counter_pin_d <= 1'b0;
      ext0_d <= 1'b0;
      ext1_d <= 1'b0;
      porta_d <= `TPWC_RST_ZERO;
      portb_d <= `TPWC_RST_ZERO;
      wake_request <= 1'b0;
      global_irq_en <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      counter_pin_d <= counter_pin;
      ext0_d <= ext_irq_zero_pin;
      ext1_d <= ext_irq_one_pin;
      porta_d <= porta_in;
      portb_d <= portb_in;
      wake_request <= |(nib_change & ~wakeup_drive_reg[3:0]);
      if (enable_irq_instruction || return_irq_instruction)
        global_irq_en <= 1'b1;
      else if (disable_irq_instruction || irq_entry)
        global_irq_en <= 1'b0;
    end
  end

  assign cpu_irq_request = global_irq_en && |(irq_status & irq_mask_reg);
endmodule

// *** bench/tpwc_sva.sv ***
// Bus, interrupt gate and watchdog pulse checks on the ports of the timer block.
`timescale 1ns/100ps
`include "tpwc_consts.vh"
module tpwc_sva (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Bus.
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Core events and results.
  input wire disable_irq_instruction,
  input wire enable_irq_instruction,
  input wire return_irq_instruction,
  input wire irq_entry,
  input wire output_drive_select,
  input wire watchdog_reset,
  input wire cpu_irq_request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire acc = hsel && hready && (htrans == `TPWC_HTRANS_NONSEQ);
  wire wacc = acc && hwrite;
  wire gie_off = (disable_irq_instruction || irq_entry) && !enable_irq_instruction
    && !return_irq_instruction;
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("Bus response is not OKAY.");
  a_write_nowait: assert property (wacc |=> hreadyout)
    else $error("Write data phase was stretched.");
  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state is wrong.");
  a_rdata_clear: assert property (acc |=> hrdata == 32'h0)
    else $error("Read data not cleared at address phase.");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("Upper read data bits are not zero.");
  a_drive_cause: assert property ($changed(output_drive_select) |-> $past(wacc, 2))
    else $error("Drive select changed without a write.");
  a_gie_clear: assert property (gie_off |=> !cpu_irq_request)
    else $error("Interrupt request after global disable.");
  a_wdt_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("Watchdog reset is longer than one cycle.");
endmodule
bind tpwc_top tpwc_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .disable_irq_instruction(disable_irq_instruction),
  .enable_irq_instruction(enable_irq_instruction),
  .return_irq_instruction(return_irq_instruction), .irq_entry(irq_entry),
  .output_drive_select(output_drive_select), .watchdog_reset(watchdog_reset),
  .cpu_irq_request(cpu_irq_request));

// *** bench/tpwc_tb_top.sv ***
// Self-checking testbench of the timer block driven over its register bus.
`timescale 1ns/100ps
`include "tpwc_consts.vh"
module tpwc_tb_top;
  logic hclk, hresetn, hsel, hwrite, itk, sub, mainc, cpin, ext0;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  logic [4:0] ev;
  logic [15:0] pv;
  logic [7:0] q, pat;
  logic [1:0] ord [4];
  wire [31:0] hrdata;
  wire hrdy, hresp, pout, drv, wake, wdr, irq;
  int fails, compares, n, h, b;
  tpwc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .instr_tick(itk), .sub_osc_clock(sub),
    .main_osc_clock(mainc), .disable_irq_instruction(ev[3]), .enable_irq_instruction(ev[2]),
    .return_irq_instruction(ev[1]), .irq_entry(ev[0]), .wdt_clear(ev[4]), .counter_pin(cpin),
    .ext_irq_zero_pin(ext0), .ext_irq_one_pin(1'b0), .porta_in(pv[7:0]), .portb_in(pv[15:8]),
    .pulse_output_pin(pout), .output_drive_select(drv), .wake_request(wake),
    .watchdog_reset(wdr), .cpu_irq_request(irq));
  initial
  begin
    hclk = 0;
    forever #10 hclk = ~hclk;
  end
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tmo(input int k);
    if (k >= 3000)
    begin
      fails++;
      report_and_stop;
    end
  endtask
  task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    do begin @(posedge hclk); k++; end while (hrdy !== 1'b1 && k < 3000);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do begin @(posedge hclk); k++; end while (hrdy !== 1'b1 && k < 3000);
    q = hrdata[7:0];
    tmo(k);
  endtask
  task wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task rc(input logic [5:0] idx, input logic [7:0] e, input string nm);
    xfer(1'b0, idx, 8'h00);
    chk(nm, {8'h0, q}, {8'h0, e});
  endtask
  task evp(input logic [4:0] e);
    ev <= e;
    @(posedge hclk);
    ev <= 5'h0;
    @(posedge hclk);
  endtask
  task ph(input logic v);
    n = 0;
    while (pout === v && n < 3000) begin @(posedge hclk); n++; end
    tmo(n);
  endtask
  task wcount(output int c);
    c = 0;
    repeat (6) begin @(posedge hclk); if (wake === 1'b1) c++; end
  endtask
  task tk(input logic p, input int cnt);
    repeat (cnt)
    begin
      cpin <= p;
      itk <= !p;
      @(posedge hclk);
      itk <= 1'b0;
      @(posedge hclk);
      cpin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, itk, sub, mainc, cpin, ext0} = 8'h0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    ev = 5'h0;
    pv = 16'h0;
    ord = '{2'd2, 2'd3, 2'd1, 2'd0};
    fails = 0;
    compares = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    hsel <= 1'b1;
    rc(`TPWC_IDX_IRQ_MASK, 8'h00, "mask reset");
    for (int i = 0; i < 3; i++)
    begin
      wr(`TPWC_IDX_HIGH_PRESET + i, 8'h5a + i);
      rc(`TPWC_IDX_HIGH_PRESET + i, 8'h5a + i, "page0 rw");
    end
    wr(`TPWC_IDX_PAGE, 8'h01);
    rc(`TPWC_IDX_IRQ_MASK, 8'h00, "mask hidden");
    rc(6'h0b, 8'h00, "unmapped");
    rc(`TPWC_IDX_WAKEUP, 8'h00, "wake reset");
    wr(`TPWC_IDX_TCC_CTRL, 8'hff);
    rc(`TPWC_IDX_TCC_CTRL, 8'hbf, "gie read only");
    for (int i = 0; i < 4; i++)
    begin
      evp(5'h1 << ord[i]);
      rc(`TPWC_IDX_TCC_CTRL, (ord[i][1] ^ ord[i][0]) ? 8'hff : 8'hbf, "gie event");
    end
    for (int i = 0; i < 8; i++)
    begin
      b = i >> 1;
      pat = (i & 1) ? 8'h5a : 8'ha5;
      h = (b == 0) ? 8'h8f : (b == 1) ? 8'h0f : 8'hff;
      wr(`TPWC_IDX_WAKEUP + b + (b > 0), pat);
      rc(`TPWC_IDX_WAKEUP + b + (b > 0), pat & h, "page1 rw");
      if (b == 0) chk("drive", drv, !(i & 1));
    end
    wr(`TPWC_IDX_PAGE, 8'h00);
    wr(`TPWC_IDX_HIGH_PRESET, 8'h01);
    wr(`TPWC_IDX_LOW_PRESET, 8'h02);
    wr(`TPWC_IDX_PAGE, 8'h01);
    wr(`TPWC_IDX_WIDTH_CTRL, 8'h88);
    wr(`TPWC_IDX_IRQ_STATUS, 8'hff);
    mainc <= 1'b1;
    for (int m = 1; m < 4; m += 2)
    begin
      wr(`TPWC_IDX_PULSE_MODE, m);
      ph(0); ph(1); ph(0); ph(1);
      chk("high phase", n, (m == 1) ? 4 : 6);
      ph(0);
      chk("low phase", n, 6);
      wr(`TPWC_IDX_PULSE_MODE, 8'h00);
      if (m == 1) rc(`TPWC_IDX_IRQ_STATUS, 8'h60, "width flags");
    end
    wr(`TPWC_IDX_IRQ_STATUS, 8'hff);
    wr(`TPWC_IDX_WIDTH_CTRL, 8'h80);
    wr(`TPWC_IDX_PULSE_MODE, 8'h01);
    repeat (40) @(posedge hclk);
    chk("high on sub source", pout, 1'b1);
    wr(`TPWC_IDX_PULSE_MODE, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(`TPWC_IDX_CNT_CTRL, i ? 8'h80 : 8'h08);
      wr(`TPWC_IDX_IRQ_STATUS, 8'hff);
      wr(`TPWC_IDX_PULSE_MODE, i ? 8'h08 : 8'h04);
      repeat (8) @(posedge hclk);
      rc(`TPWC_IDX_IRQ_STATUS, i ? 8'h10 : 8'h08, "counter flag");
    end
    wr(`TPWC_IDX_PULSE_MODE, 8'h00);
    mainc <= 1'b0;
    wr(`TPWC_IDX_TCC_CTRL, 8'h00);
    evp(5'h04);
    wr(`TPWC_IDX_PAGE, 8'h00);
    wr(`TPWC_IDX_IRQ_MASK, 8'h02);
    wr(`TPWC_IDX_IRQ_STATUS, 8'hff);
    ext0 <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("irq masked in", irq, 1'b1);
    rc(`TPWC_IDX_IRQ_STATUS, 8'h02, "rising flag");
    wr(`TPWC_IDX_IRQ_MASK, 8'h00);
    @(posedge hclk);
    chk("irq masked out", irq, 1'b0);
    wr(`TPWC_IDX_PAGE, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      wr(`TPWC_IDX_TCC_CTRL, 8'h80);
      wr(`TPWC_IDX_IRQ_STATUS, 8'hff);
      ext0 <= i[0];
      repeat (3) @(posedge hclk);
      rc(`TPWC_IDX_IRQ_STATUS, i ? 8'h00 : 8'h02, "falling edge mode");
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(`TPWC_IDX_WAKEUP, ~(8'h1 << k) & 8'h0f);
      pv[4 * k] <= ~pv[4 * k];
      wcount(n);
      chk("wake enabled", n, 1);
      pv[4 * ((k + 1) % 4)] <= ~pv[4 * ((k + 1) % 4)];
      wcount(n);
      chk("wake disabled", n, 0);
    end
    sub <= 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      wr(`TPWC_IDX_WDT_CTRL, (c < 2) ? 8'h08 + c : 8'h00);
      evp(5'h10);
      b = 256 << c;
      n = 0;
      while (wdr !== 1'b1 && n < 1200) begin @(posedge hclk); n++; end
      chk("watchdog time", (c < 2) ? (n >= b && n <= b + 4) : n, (c < 2) ? 1 : 1200);
    end
    sub <= 1'b0;
    wr(`TPWC_IDX_IRQ_STATUS, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      pat = (i == 0) ? 8'h20 : (i == 1) ? 8'h30 : (i == 2) ? 8'h2a : 8'h09;
      wr(`TPWC_IDX_TCC_CTRL, pat);
      wr(`TPWC_IDX_TCC_VALUE, (i == 0) ? 8'hfe : (i == 1) ? 8'h10 : 8'h00);
      tk(pat[5], (i == 0) ? 2 : (i == 1) ? 3 : (i == 2) ? 16 : 8);
      rc(`TPWC_IDX_TCC_VALUE, (i == 0) ? 8'h00 : (i == 1) ? 8'h13 : 8'h02, "tcc");
      if (i == 0) rc(`TPWC_IDX_IRQ_STATUS, 8'h01, "tcc flag");
    end
    report_and_stop;
  end
endmodule
